// ### core/dmc_if.sv
/*
  interface carrying one ahb master port's request from the channel
  engine to its master port module.
  assumes both ends run on the same clock.
*/
interface dmc_master_if;
  logic        req;
  logic        write;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [2:0]  size;
  logic [2:0]  burst;
  logic [3:0]  prot;
  logic        lock;
  logic        idle_gap;
  logic        done;
  logic        err;
  logic [31:0] rdata;
  modport engine (output req, write, addr, wdata, size, burst, prot, lock,
                  idle_gap, input done, err, rdata);
  modport port   (input req, write, addr, wdata, size, burst, prot, lock,
                  idle_gap, output done, err, rdata);
endinterface

// ### core/dmc_master_port.sv
/*
  one ahb master port: drives address phase from the engine request and
  reports completion of each beat. nothing is shared between instances.
  assumes hready and hresp from the system, on the common clock.
*/
module dmc_master_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // engine side
  dmc_master_if.port       eng,
  // ahb master pins
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [2:0]       hburst,
  output logic [3:0]       hprot,
  output logic             hlock,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic        hresp,
  input  wire logic [31:0] hrdata
);
  logic data_phase_r;
  logic first_r;
  wire  issue = eng.req && hready && !eng.idle_gap;

  always_ff @(posedge clk) begin
    if (reset) begin
      haddr        <= dmc_pkg::RESET_WORD;
      htrans       <= dmc_pkg::DMC_HTRANS_IDLE;
      hwrite       <= 1'b0;
      hsize        <= 3'h0;
      hburst       <= dmc_pkg::HBURST_SINGLE;
      hprot        <= 4'h1;
      hlock        <= 1'b0;
      hwdata       <= dmc_pkg::RESET_WORD;
      data_phase_r <= 1'b0;
      first_r      <= 1'b1;
    end else if (hready) begin
      hwdata       <= eng.wdata;
      data_phase_r <= issue;
      hlock        <= eng.lock;
      if (issue) begin
        haddr  <= eng.addr;
        htrans <= first_r ? dmc_pkg::DMC_HTRANS_NSEQ : dmc_pkg::DMC_HTRANS_SEQ;
        hwrite <= eng.write;
        hsize  <= eng.size;
        hburst <= eng.burst;
        hprot  <= eng.prot;
        first_r <= 1'b0;
      end else begin
        htrans  <= dmc_pkg::DMC_HTRANS_IDLE;
        first_r <= 1'b1;
      end
    end
  end

  assign eng.done  = data_phase_r && hready;
  assign eng.err   = data_phase_r && hresp;
  assign eng.rdata = hrdata;
endmodule

// ### core/dmc_pkg.sv
/*
  package for the dma master-side control block: constants, field layout,
  state and transfer-type enumerations.
  assumes a single 250 mhz clock with synchronous active-high reset.
*/
package dmc_pkg;
  // channel configuration fields
  localparam int CFG_LOCK_BIT   = 16;
  localparam int CFG_ON_BIT     = 0;
  localparam int CFG_SRC_LSB    = 1;
  localparam int CFG_DST_LSB    = 6;
  localparam int CFG_FLOW_LSB   = 11;
  localparam int CFG_ITC_BIT    = 15;
  localparam int CFG_IERR_BIT   = 14;
  localparam int CFG_LOWPRI_BIT = 17;
  // channel control fields
  localparam int CTL_COUNT_LSB  = 0;
  localparam int CTL_SBURST_LSB = 12;
  localparam int CTL_SW_LSB     = 18;
  localparam int CTL_DW_LSB     = 21;
  localparam int CTL_PROT_LSB   = 28;
  localparam int CTL_INC_BIT    = 31;
  // register offsets
  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_SRCADDR = 8'h08;
  localparam logic [7:0] OFS_DSTADDR = 8'h0c;
  localparam logic [7:0] OFS_DESC    = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_IRQ     = 8'h18;
  localparam logic [7:0] OFS_IRQCLR  = 8'h1c;
  // reset values and limits
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic [31:0] DESC_LIMIT   = 32'h0fff_fff0;
  localparam int          DESC_WORDS   = 4;
  localparam logic [4:0]  LOWPRI_MAX   = 5'h10;
  localparam logic [2:0]  MIN_LOCK_BST = 3'h1;
  localparam logic [3:0]  PROT_DESC    = 4'hb;
  localparam logic [2:0]  WIDTH_MAX    = 3'h2;
  localparam logic [11:0] COUNT_ZERO   = 12'h000;

  typedef enum logic [1:0] {
    DMC_HTRANS_IDLE = 2'h0,
    DMC_HTRANS_NSEQ = 2'h2,
    DMC_HTRANS_SEQ  = 2'h3
  } dmc_htrans_e;

  typedef enum {
    DMC_IDLE, DMC_DESC, DMC_SRC, DMC_DST, DMC_GAP, DMC_ACK
  } dmc_state_e;

  // ahb burst codes for 1, 4, 8 beats (incr) and 4 beats (wrap)
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HBURST_INCR4  = 3'h3;
  localparam logic [2:0] HBURST_INCR8  = 3'h5;
  localparam logic [2:0] HBURST_WRAP4  = 3'h2;
endpackage

// ### core/dmc_top.sv
/*
  single-channel dma engine showing master-side control: protection,
  lock and size attributes, interrupts, peripheral request handshake,
  channel disable latency and low-priority bus release.
  assumes peripherals keep the handshake rules and software programs the
  channel only while disabled.
*/
// Local design decisions: the address map and the strobed register port.
module dmc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [31:0]      reg_rdata,
  // peripheral handshake
  input  wire logic        single_request,
  input  wire logic        burst_request,
  input  wire logic        last_single_request,
  input  wire logic        last_burst_request,
  output logic             request_clear,
  output logic             terminal_count_response,
  // interrupts
  output logic             error_irq,
  output logic             terminal_count_irq,
  output logic             combined_irq,
  // master 1 (source side)
  output logic [31:0]      m1_haddr,
  output logic [1:0]       m1_htrans,
  output logic             m1_hwrite,
  output logic [2:0]       m1_hsize,
  output logic [2:0]       m1_hburst,
  output logic [3:0]       m1_hprot,
  output logic             m1_hlock,
  output logic [31:0]      m1_hwdata,
  input  wire logic        m1_hready,
  input  wire logic        m1_hresp,
  input  wire logic [31:0] m1_hrdata,
  // master 2 (destination side)
  output logic [31:0]      m2_haddr,
  output logic [1:0]       m2_htrans,
  output logic             m2_hwrite,
  output logic [2:0]       m2_hsize,
  output logic [2:0]       m2_hburst,
  output logic [3:0]       m2_hprot,
  output logic             m2_hlock,
  output logic [31:0]      m2_hwdata,
  input  wire logic        m2_hready,
  input  wire logic        m2_hresp,
  input  wire logic [31:0] m2_hrdata
);
  // width code to bytes
  function automatic logic [2:0] wbytes(input logic [2:0] w);
    wbytes = (w == 3'h0) ? 3'h1 : (w == 3'h1) ? 3'h2 : 3'h4;
  endfunction

  // handshake inputs from pins
  logic [3:0] req_meta_r, req_sync_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      req_meta_r <= 4'h0;
      req_sync_r <= 4'h0;
    end else begin
      req_meta_r <= {last_burst_request, last_single_request,
                     burst_request, single_request};
      req_sync_r <= req_meta_r;
    end
  end
  wire any_req  = |req_sync_r;
  wire last_req = req_sync_r[3] | req_sync_r[2];

  // registers
  logic [31:0] cfg_r, ctl_r, src_r, dst_r, desc_r;
  logic [11:0] dst_done_r;
  logic        irq_tc_r, irq_err_r, busy_r;
  logic [31:0] rdata_nxt;
  logic [4:0]  lp_cnt_r;
  logic [1:0]  beat_r;
  logic [31:0] fifo_r;
  logic        fifo_full_r;
  dmc_pkg::dmc_state_e st_r;

  wire        ch_on     = cfg_r[dmc_pkg::CFG_ON_BIT];
  wire        lock_en   = cfg_r[dmc_pkg::CFG_LOCK_BIT];
  wire        low_pri   = cfg_r[dmc_pkg::CFG_LOWPRI_BIT];
  wire [2:0]  flow      = cfg_r[dmc_pkg::CFG_FLOW_LSB +: 3];
  wire [11:0] count     = ctl_r[dmc_pkg::CTL_COUNT_LSB +: 12];
  wire [2:0]  sburst    = ctl_r[dmc_pkg::CTL_SBURST_LSB +: 3];
  wire [2:0]  sw        = ctl_r[dmc_pkg::CTL_SW_LSB +: 3];
  wire [2:0]  dw        = ctl_r[dmc_pkg::CTL_DW_LSB +: 3];
  wire [2:0]  prot_set  = ctl_r[dmc_pkg::CTL_PROT_LSB +: 3];
  wire        dev_flow  = (flow == 3'h0);
  wire        dst_flow  = (flow == 3'h4);
  wire        same_w    = (sw == dw);
  wire        long_bst  = (sburst >= dmc_pkg::MIN_LOCK_BST);
  wire        keep_lock = lock_en && same_w && long_bst;
  wire        sel_cfg   = reg_addr == dmc_pkg::OFS_CONFIG;
  wire        sel_ctl   = reg_addr == dmc_pkg::OFS_CONTROL;
  wire        sel_src   = reg_addr == dmc_pkg::OFS_SRCADDR;
  wire        sel_dst   = reg_addr == dmc_pkg::OFS_DSTADDR;
  wire        sel_desc  = reg_addr == dmc_pkg::OFS_DESC;
  wire        sel_stat  = reg_addr == dmc_pkg::OFS_STATUS;
  wire        sel_irq   = reg_addr == dmc_pkg::OFS_IRQ;
  wire        sel_clr   = reg_addr == dmc_pkg::OFS_IRQCLR;
  // remaining count in source units: destination beats scaled by width ratio
  wire [14:0] remain    = 15'((15'(count) * 15'(wbytes(dw)) -
                          15'(dst_done_r) * 15'(wbytes(dw))) / 15'(wbytes(sw)));

  dmc_master_if m1 ();
  dmc_master_if m2 ();

  // attribute generation
  wire in_desc = (st_r == dmc_pkg::DMC_DESC);
  // single transfers keep one beat outstanding; descriptor beats pipeline
  logic       m1_pend_r, m2_pend_r;
  logic [2:0] desc_ofs_r;
  wire        m1_take = m1.req && m1_hready && !m1.idle_gap;
  wire        m2_take = m2.req && m2_hready && !m2.idle_gap;
  always_ff @(posedge clk) begin
    if (reset) begin
      m1_pend_r  <= 1'b0;
      m2_pend_r  <= 1'b0;
      desc_ofs_r <= 3'h0;
    end else begin
      m1_pend_r  <= (m1_pend_r && !m1.done) || (m1_take && !in_desc);
      m2_pend_r  <= (m2_pend_r && !m2.done) || m2_take;
      desc_ofs_r <= in_desc ? 3'(desc_ofs_r + 3'(m1_take)) : 3'h0;
    end
  end
  wire [3:0] prot_ch = in_desc ? dmc_pkg::PROT_DESC
                               : {prot_set[2], prot_set[1], prot_set[0], 1'b1};
  assign m1.req      = ch_on && ((in_desc && !desc_ofs_r[2]) ||
                                 (st_r == dmc_pkg::DMC_SRC && !m1_pend_r));
  assign m1.write    = 1'b0;
  assign m1.addr     = in_desc ? desc_r + 32'({desc_ofs_r[1:0], 2'b00})
                               : src_r;
  assign m1.wdata    = dmc_pkg::RESET_WORD;
  assign m1.size     = in_desc ? dmc_pkg::WIDTH_MAX : sw;
  assign m1.burst    = in_desc ? dmc_pkg::HBURST_WRAP4
                               : dmc_pkg::HBURST_INCR4;
  assign m1.prot     = {prot_ch[3:1], 1'b1};
  assign m1.lock     = lock_en && (st_r == dmc_pkg::DMC_SRC ||
                                   (keep_lock && st_r == dmc_pkg::DMC_DST));
  assign m1.idle_gap = (st_r == dmc_pkg::DMC_GAP);
  assign m2.req      = ch_on && (st_r == dmc_pkg::DMC_DST) && !m2_pend_r;
  assign m2.write    = 1'b1;
  assign m2.addr     = dst_r;
  assign m2.wdata    = fifo_r;
  assign m2.size     = dw;
  assign m2.burst    = dmc_pkg::HBURST_SINGLE;
  assign m2.prot     = {prot_set[2], prot_set[1], prot_set[0], 1'b1};
  assign m2.lock     = lock_en && (st_r == dmc_pkg::DMC_DST);
  assign m2.idle_gap = (st_r == dmc_pkg::DMC_GAP);

  // separate port instances, same clock
  dmc_master_port u_m1 (
    .clk(clk), .reset(reset), .eng(m1),
    .haddr(m1_haddr), .htrans(m1_htrans), .hwrite(m1_hwrite),
    .hsize(m1_hsize), .hburst(m1_hburst), .hprot(m1_hprot),
    .hlock(m1_hlock), .hwdata(m1_hwdata), .hready(m1_hready),
    .hresp(m1_hresp), .hrdata(m1_hrdata)
  );
  dmc_master_port u_m2 (
    .clk(clk), .reset(reset), .eng(m2),
    .haddr(m2_haddr), .htrans(m2_htrans), .hwrite(m2_hwrite),
    .hsize(m2_hsize), .hburst(m2_hburst), .hprot(m2_hprot),
    .hlock(m2_hlock), .hwdata(m2_hwdata), .hready(m2_hready),
    .hresp(m2_hresp), .hrdata(m2_hrdata)
  );

  // channel engine
  wire zero_hold = dev_flow && (count == dmc_pkg::COUNT_ZERO);
  wire all_done  = dev_flow && (dst_done_r == count);
  wire fifo_meets_last = dst_flow && fifo_full_r && last_req;
  // fifo alone answers the destination's last request
  wire tc_to_src = ch_on && (st_r == dmc_pkg::DMC_IDLE) && fifo_meets_last;
  wire any_err   = m1.err || m2.err;
  wire set_tc    = (st_r == dmc_pkg::DMC_DST) && m2.done &&
                   ((dev_flow && 12'(dst_done_r + 12'h1) == count) ||
                    (!dev_flow && last_req));
  localparam logic [4:0] LP_LIMIT = dmc_pkg::LOWPRI_MAX;
  wire lp_expire = low_pri && (lp_cnt_r >= LP_LIMIT - 5'h1);

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r        <= dmc_pkg::DMC_IDLE;
      beat_r      <= 2'h0;
      fifo_r      <= dmc_pkg::RESET_WORD;
      fifo_full_r <= 1'b0;
      dst_done_r  <= dmc_pkg::COUNT_ZERO;
      busy_r      <= 1'b0;
      lp_cnt_r    <= 5'h0;
    end else begin
      lp_cnt_r <= (st_r == dmc_pkg::DMC_GAP || !low_pri) ? 5'h0
                  : 5'(lp_cnt_r + 5'h1);
      busy_r   <= ch_on || (st_r != dmc_pkg::DMC_IDLE);
      case (st_r)
        dmc_pkg::DMC_IDLE: begin
          beat_r <= 2'h0;
          if (ch_on && desc_r != dmc_pkg::RESET_WORD && !zero_hold)
            st_r <= dmc_pkg::DMC_DESC;
          else if (ch_on && !zero_hold && !all_done &&
                   (dev_flow || any_req))
            st_r <= fifo_meets_last ? dmc_pkg::DMC_DST : dmc_pkg::DMC_SRC;
        end
        // a disabled channel leaves in any cycle with no completing beat, even with a beat still waiting
        dmc_pkg::DMC_DESC: begin
          if (m1.done) begin
            beat_r <= 2'(beat_r + 2'h1);
            if (beat_r == 2'(dmc_pkg::DESC_WORDS - 1))
              st_r <= dmc_pkg::DMC_IDLE;
          end else if (!ch_on)
            st_r <= dmc_pkg::DMC_IDLE;
        end
        dmc_pkg::DMC_SRC: begin
          if (m1.done) begin
            fifo_r      <= m1.rdata;
            fifo_full_r <= 1'b1;
            st_r        <= dmc_pkg::DMC_DST;
          end else if (!ch_on)
            st_r <= dmc_pkg::DMC_IDLE;
        end
        dmc_pkg::DMC_DST: begin
          if (m2.done) begin
            fifo_full_r <= 1'b0;
            dst_done_r  <= 12'(dst_done_r + 12'h1);
            st_r <= low_pri ? dmc_pkg::DMC_GAP : dmc_pkg::DMC_ACK;
          end else if (!ch_on)
            st_r <= dmc_pkg::DMC_IDLE;
        end
        dmc_pkg::DMC_GAP:
          st_r <= dmc_pkg::DMC_ACK;
        dmc_pkg::DMC_ACK:
          st_r <= dmc_pkg::DMC_IDLE;
        default:
          st_r <= dmc_pkg::DMC_IDLE;
      endcase
      if (lp_expire && st_r != dmc_pkg::DMC_IDLE &&
          st_r != dmc_pkg::DMC_GAP)
        st_r <= dmc_pkg::DMC_GAP;
      if (reg_write && sel_ctl)
        dst_done_r <= dmc_pkg::COUNT_ZERO;
    end
  end

  // register writes; hardware clears channel enable on error, or on completion only when dev_flow
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_r     <= dmc_pkg::RESET_WORD;
      ctl_r     <= dmc_pkg::RESET_WORD;
      src_r     <= dmc_pkg::RESET_WORD;
      dst_r     <= dmc_pkg::RESET_WORD;
      desc_r    <= dmc_pkg::RESET_WORD;
      irq_tc_r  <= 1'b0;
      irq_err_r <= 1'b0;
    end else begin
      if (reg_write && sel_cfg) cfg_r  <= reg_wdata;
      if (reg_write && sel_ctl) ctl_r  <= reg_wdata;
      if (reg_write && sel_src) src_r  <= reg_wdata;
      if (reg_write && sel_dst) dst_r  <= reg_wdata;
      if (reg_write && sel_desc) desc_r <= reg_wdata;
      if (st_r == dmc_pkg::DMC_DESC && m1.done)
        desc_r <= (beat_r == 2'(dmc_pkg::DESC_WORDS - 1)) ?
                  dmc_pkg::RESET_WORD : desc_r;
      if (any_err || (set_tc && dev_flow))
        cfg_r[dmc_pkg::CFG_ON_BIT] <= 1'b0;
      // set wins over clear
      irq_tc_r  <= set_tc  || (irq_tc_r  && !(reg_write && sel_clr &&
                                               reg_wdata[0]));
      irq_err_r <= any_err || (irq_err_r && !(reg_write && sel_clr &&
                                               reg_wdata[1]));
    end
  end

  // read mux and pin outputs
  always_comb begin
    rdata_nxt = dmc_pkg::RESET_WORD;
    if (sel_cfg)
      rdata_nxt = cfg_r;
    else if (sel_ctl)
      rdata_nxt = {ctl_r[31:12], remain[11:0]};
    else if (sel_src)
      rdata_nxt = src_r;
    else if (sel_dst)
      rdata_nxt = dst_r;
    else if (sel_desc)
      rdata_nxt = desc_r;
    else if (sel_stat)
      rdata_nxt = {31'h0, busy_r};
    else if (sel_irq)
      rdata_nxt = {30'h0, irq_err_r, irq_tc_r};
  end

  wire tc_mask  = cfg_r[dmc_pkg::CFG_ITC_BIT];
  wire err_mask = cfg_r[dmc_pkg::CFG_IERR_BIT];
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata               <= dmc_pkg::RESET_WORD;
      request_clear           <= 1'b0;
      terminal_count_response <= 1'b0;
      error_irq               <= 1'b0;
      terminal_count_irq      <= 1'b0;
      combined_irq            <= 1'b0;
    end else begin
      reg_rdata     <= reg_read ? rdata_nxt : dmc_pkg::RESET_WORD;
      request_clear <= (st_r == dmc_pkg::DMC_ACK) && any_req;
      terminal_count_response <= set_tc || tc_to_src;
      error_irq          <= irq_err_r && err_mask;
      terminal_count_irq <= irq_tc_r && tc_mask;
      combined_irq       <= (irq_err_r && err_mask) ||
                            (irq_tc_r && tc_mask);
    end
  end
endmodule

// ### tb/dmc_far_side.sv
/*
  far-side model: ahb slaves on both masters and one peripheral that
  requests transfers.
  assumes the common clock and a bench that pulses want_req.
*/
module dmc_far_side (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   reset,
  // bench control
  input  wire logic   want_req,
  input  wire logic   slow,
  // ahb slave answers
  output logic        m1_hready,
  output logic        m1_hresp,
  output logic [31:0] m1_hrdata,
  output logic        m2_hready,
  output logic        m2_hresp,
  output logic [31:0] m2_hrdata,
  // peripheral handshake
  output logic        single_request,
  output logic        burst_request,
  output logic        last_single_request,
  output logic        last_burst_request,
  input  wire logic   request_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pat_r;
  logic        tog_r;
  // read data never holds still, so stale values cannot pass
  always_ff @(posedge clk) begin
    if (reset) begin
      pat_r <= 32'h0000_0000;
      tog_r <= 1'b0;
    end else begin
      pat_r <= pat_r + 32'h9e37_79b9;
      tog_r <= ~tog_r;
    end
  end
  // slow mode inserts a wait state every other cycle
  assign m1_hready = ~slow | tog_r;
  assign m2_hready = ~slow | ~tog_r;
  assign m1_hrdata = pat_r;
  assign m2_hrdata = ~pat_r;
  assign m1_hresp = 1'b0;
  assign m2_hresp = 1'b0;
  assign burst_request = 1'b0;
  assign last_single_request = 1'b0;
  assign last_burst_request = 1'b0;
  always_ff @(posedge clk) begin
    if (reset || request_clear) begin
      single_request <= 1'b0;
    end else if (want_req) begin
      single_request <= 1'b1;
    end
  end
endmodule

// ### tb/dmc_top_asserts.sv
/*
  checker for dmc_top: protection, irq, handshake and bus release.
  assumes it is bound to dmc_top with ports connected by name.
*/
module dmc_top_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // handshake
  input wire logic        single_request,
  input wire logic        burst_request,
  input wire logic        last_single_request,
  input wire logic        last_burst_request,
  input wire logic        request_clear,
  // interrupts
  input wire logic        error_irq,
  input wire logic        terminal_count_irq,
  input wire logic        combined_irq,
  // masters
  input wire logic [1:0]  m1_htrans,
  input wire logic [2:0]  m1_hsize,
  input wire logic [2:0]  m1_hburst,
  input wire logic [3:0]  m1_hprot,
  input wire logic        m1_hready,
  input wire logic [1:0]  m2_htrans,
  input wire logic [3:0]  m2_hprot
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic       req_any;
  logic       desc_go;
  logic [4:0] beats_r;
  logic [3:0] since_r;
  assign req_any = single_request | burst_request | last_single_request
                 | last_burst_request;
  assign desc_go = (m1_htrans == dmc_pkg::DMC_HTRANS_NSEQ)
                 && (m1_hburst == dmc_pkg::HBURST_WRAP4);
  // beats accepted on master 1 since it last went idle
  always_ff @(posedge clk) begin
    if (reset || m1_htrans == dmc_pkg::DMC_HTRANS_IDLE) begin
      beats_r <= 5'h00;
    end else if (m1_hready && beats_r != 5'h1f) begin
      beats_r <= beats_r + 5'h01;
    end
  end
  // cycles since any request line was last high
  always_ff @(posedge clk) begin
    if (reset) begin
      since_r <= 4'hf;
    end else if (req_any) begin
      since_r <= 4'h0;
    end else if (since_r != 4'hf) begin
      since_r <= since_r + 4'h1;
    end
  end
  chk_prot_data_m1: assert property (
    m1_htrans != dmc_pkg::DMC_HTRANS_IDLE |-> m1_hprot[0])
    else $error("m1 data protection bit low");
  chk_prot_data_m2: assert property (
    m2_htrans != dmc_pkg::DMC_HTRANS_IDLE |-> m2_hprot[0])
    else $error("m2 data protection bit low");
  chk_desc_prot_size: assert property (
    desc_go |-> m1_hprot == dmc_pkg::PROT_DESC && m1_hsize == 3'h2)
    else $error("descriptor fetch attributes wrong");
  chk_irq_or_all: assert property (
    combined_irq == (error_irq | terminal_count_irq))
    else $error("combined irq is not the or");
  chk_clear_pulse_one: assert property (
    request_clear |=> !request_clear)
    else $error("clear longer than one cycle");
  chk_clear_has_req: assert property (
    request_clear |-> since_r <= 4'h4)
    else $error("clear without a recent request");
  chk_bus_release_max: assert property (
    beats_r <= dmc_pkg::LOWPRI_MAX)
    else $error("master 1 busy beyond sixteen beats");
  chk_reset_prot_idle: assert property (disable iff (1'b0)
    reset |=> m1_hprot == 4'h1 && m2_hprot == 4'h1 && m1_htrans == 2'h0)
    else $error("reset state of master outputs wrong");
  cover property (desc_go);
  cover property ($rose(request_clear));
  cover property ($rose(combined_irq));
endmodule

// ### tb/dmc_top_test.sv
/*
  testbench for dmc_top: register rows, transfers, masking, zero count.
  assumes dmc_far_side answers the masters and the peripheral lines.
*/
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("[FAIL] %0t got %0h want %0h", $time, got, exp); \
  end \
end
module dmc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dmc_row_s;
  logic clk, reset, reg_write, reg_read, want_req, slow;
  logic single_request, burst_request, last_single_request, last_burst_request;
  logic request_clear, terminal_count_response;
  logic error_irq, terminal_count_irq, combined_irq;
  logic m1_hready, m1_hresp, m2_hready, m2_hresp;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, m1_hrdata, m2_hrdata, rd;
  logic [1:0] m1_htrans, m2_htrans;
  logic [2:0] m1_hsize, m2_hsize, m1_hburst, s1, s2;
  logic [3:0] m1_hprot, m2_hprot, p1, p2, pd;
  int bad_count, num_checks, m1_starts, n, tc_seen;
  dmc_row_s rows[4] = '{
    '{8'h08, 32'h0000_1000, 32'h0000_1000},
    '{8'h0c, 32'h0000_2000, 32'h0000_2000},
    '{8'h10, 32'h0000_0000, 32'h0000_0000},
    '{8'h40, 32'hffff_ffff, 32'h0000_0000}};

  dmc_top DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .single_request(single_request),
    .burst_request(burst_request), .last_single_request(last_single_request),
    .last_burst_request(last_burst_request), .request_clear(request_clear),
    .terminal_count_response(terminal_count_response),
    .error_irq(error_irq), .terminal_count_irq(terminal_count_irq),
    .combined_irq(combined_irq), .m1_haddr(), .m1_htrans(m1_htrans),
    .m1_hwrite(), .m1_hsize(m1_hsize), .m1_hburst(m1_hburst),
    .m1_hprot(m1_hprot), .m1_hlock(), .m1_hwdata(), .m1_hready(m1_hready),
    .m1_hresp(m1_hresp), .m1_hrdata(m1_hrdata), .m2_haddr(),
    .m2_htrans(m2_htrans), .m2_hwrite(), .m2_hsize(m2_hsize), .m2_hburst(),
    .m2_hprot(m2_hprot), .m2_hlock(), .m2_hwdata(), .m2_hready(m2_hready),
    .m2_hresp(m2_hresp), .m2_hrdata(m2_hrdata));
  dmc_far_side far (.clk(clk), .reset(reset), .want_req(want_req),
    .slow(slow), .m1_hready(m1_hready), .m1_hresp(m1_hresp),
    .m1_hrdata(m1_hrdata), .m2_hready(m2_hready), .m2_hresp(m2_hresp),
    .m2_hrdata(m2_hrdata), .single_request(single_request),
    .burst_request(burst_request), .last_single_request(last_single_request),
    .last_burst_request(last_burst_request), .request_clear(request_clear));

  always #2 clk = ~clk;
  // attributes of the last data transfer seen on each master
  always @(posedge clk) begin
    if (m1_htrans === 2'h2 && m1_hburst !== dmc_pkg::HBURST_WRAP4) begin
      m1_starts++;
      p1 <= m1_hprot;
      s1 <= m1_hsize;
    end else if (m1_htrans === 2'h2) begin
      pd <= m1_hprot;
    end
    if (terminal_count_response === 1'b1) tc_seen++;
    if (m2_htrans === 2'h2) begin
      p2 <= m2_hprot;
      s2 <= m2_hsize;
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic expire();
    bad_count++;
    $display("[FAIL] %0t timeout", $time);
    finish_test();
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic reg_rd(input logic [7:0] a);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    rd = reg_rdata;
    @(posedge clk);
  endtask
  task automatic poll(input logic [7:0] a, input logic v);
    for (int i = 0; i < 300; i++) begin
      reg_rd(a);
      if (rd[0] === v) return;
    end
    expire();
  endtask
  // program while off, then raise one request
  task automatic chan_go(input logic [31:0] ctl, input logic [31:0] cfg);
    reg_wr(dmc_pkg::OFS_CONFIG, 32'h0000_0000);
    poll(dmc_pkg::OFS_STATUS, 1'b0);
    reg_wr(dmc_pkg::OFS_CONTROL, ctl);
    reg_wr(dmc_pkg::OFS_CONFIG, cfg);
    want_req <= 1'b1;
    @(posedge clk);
    want_req <= 1'b0;
  endtask

  initial begin
    {clk, reg_write, reg_read, want_req, slow} = '0;
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(m1_hprot, 4'h1)
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d);
      reg_rd(rows[i].a);
      `CHK(rd, rows[i].e)
    end
    // halfword source into word destination, user, bufferable, cacheable
    slow <= 1'b1;
    chan_go(32'h6044_0004, 32'h0000_c001);
    for (n = 0; n < 2000 && terminal_count_irq !== 1'b1; n++) @(posedge clk);
    if (n == 2000) expire();
    `CHK(terminal_count_irq, 1'b1)
    `CHK(combined_irq, 1'b1)
    `CHK(error_irq, 1'b0)
    `CHK(p1, 4'hd)
    `CHK(p2, 4'hd)
    `CHK(s1, 3'h1)
    `CHK(s2, 3'h2)
    `CHK(single_request, 1'b0)
    `CHK(tc_seen, 1)
    reg_rd(dmc_pkg::OFS_CONTROL);
    `CHK(rd[11:0], 12'h000)
    reg_wr(dmc_pkg::OFS_IRQCLR, 32'h0000_0003);
    @(negedge clk);
    `CHK(combined_irq, 1'b0)
    // low priority, terminal count masked, word to word
    slow <= 1'b0;
    reg_wr(dmc_pkg::OFS_DESC, 32'h0000_3000);
    chan_go(32'h0049_0008, 32'h0002_4001);
    poll(dmc_pkg::OFS_IRQ, 1'b1);
    `CHK(terminal_count_irq, 1'b0)
    `CHK(combined_irq, 1'b0)
    `CHK(s1, 3'h2)
    `CHK(pd, 4'hb)
    reg_wr(dmc_pkg::OFS_IRQCLR, 32'h0000_0003);
    // zero count with the device in charge of flow
    chan_go(32'h0049_0000, 32'h0000_c001);
    n = m1_starts;
    repeat (60) @(posedge clk);
    `CHK(m1_starts, n)
    reg_rd(dmc_pkg::OFS_STATUS);
    `CHK(rd[0], 1'b1)
    // start a transfer, then cut it off while a beat is on the bus
    chan_go(32'h0049_0008, 32'h0000_c001);
    chan_go(32'h0049_0000, 32'h0000_0000);
    reg_rd(dmc_pkg::OFS_IRQ);
    `CHK(rd[1:0], 2'h0)
    finish_test();
  end
endmodule
bind dmc_top dmc_top_asserts u_chk (.clk(clk), .reset(reset),
  .single_request(single_request), .burst_request(burst_request),
  .last_single_request(last_single_request),
  .last_burst_request(last_burst_request), .request_clear(request_clear),
  .error_irq(error_irq), .terminal_count_irq(terminal_count_irq),
  .combined_irq(combined_irq), .m1_htrans(m1_htrans), .m1_hsize(m1_hsize),
  .m1_hburst(m1_hburst), .m1_hprot(m1_hprot), .m1_hready(m1_hready),
  .m2_htrans(m2_htrans), .m2_hprot(m2_hprot));
